// >>> rtl/rx_cell_header_screen.sv
// receive cell header screen: apb register file, header capture, screening and forwarding
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module rx_cell_header_screen
    import rx_screen_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              reset_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]       pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic      [31:0]       prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // receive cell octets, same clock domain
    input  wire logic              rx_valid_in,
    input  wire rx_beat_s          rx_beat_in,
    // screened cells toward the host cell port
    output logic                   fwd_valid_out,
    output fwd_beat_s              fwd_beat_out
);

    // ------------------------------------------------------------------
    // overview
    // ------------------------------------------------------------------
    // software programs a 32-bit expected header and a 32-bit ignore mask,
    // one byte register per header octet. octet 1 is the first octet on the
    // link and sits in bits 31:24 of every 32-bit view used below.
    //
    // cells arrive one octet per valid cycle on the same clock. the first four
    // octets are gathered; when the fourth arrives the header is judged at
    // once, without waiting a cycle, so the header beat leaves one cycle after
    // the fourth octet and the body keeps the same one-cycle latency.
    //
    // limitations a user must know:
    //  - there is no back-pressure toward the receive path and no buffer
    //    toward the host port; the host side must take one beat per cycle.
    //  - a mask or pattern written in the middle of a cell header can give a
    //    verdict on a mix of old and new bytes. software should change the
    //    screen between cells, or accept one odd verdict.
    //  - a cell cut short by a new start is not closed toward the host port;
    //    the host sees a fresh start beat and must drop the partial cell.
    //  - the header error check octet is forwarded but never checked here.
    //
    // the apb side always answers in the access cycle after setup. there are
    // no wait states, which keeps the answer path a single flip-flop stage.

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0]  expected_octet [4];
    logic [7:0]  ignore_octet   [4];
    logic [15:0] cells_passed;
    logic [15:0] cells_blocked;
    logic [15:0] cells_truncated;
    logic [15:0] stray_octets;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic [7:0] reg_idx      = paddr_in[IDX_LSB +: 8];
    wire logic       word_aligned = (paddr_in[IDX_LSB-1:0] == 2'b00);
    wire logic       setup_phase  = psel_in && !penable_in;
    wire logic       access_done  = psel_in && penable_in && pready_out;
    wire logic       write_done   = access_done && pwrite_in;

    wire logic hit_expected = word_aligned &&
                              (reg_idx >= IDX_EXPECTED_OCTET1) &&
                              (reg_idx <= IDX_EXPECTED_OCTET4);
    wire logic hit_ignore   = word_aligned &&
                              (reg_idx >= IDX_IGNORE_OCTET1) &&
                              (reg_idx <= IDX_IGNORE_OCTET4);
    wire logic hit_counts   = word_aligned && (reg_idx == IDX_CELL_COUNTS);
    wire logic hit_errors   = word_aligned && (reg_idx == IDX_FRAME_ERRORS);
    wire logic hit_any      = hit_expected || hit_ignore || hit_counts || hit_errors;

    // octet slot within the group of four byte registers
    wire logic [1:0] slot = reg_idx[1:0];

    wire logic wr_expected = write_done && hit_expected && pstrb_in[0];
    wire logic wr_ignore   = write_done && hit_ignore && pstrb_in[0];
    // any write to a counter register clears both counters it holds
    wire logic clr_counts  = write_done && hit_counts;
    wire logic clr_errors  = write_done && hit_errors;

    // read mux; narrow registers sit in the low byte, upper bits read zero
    logic [31:0] read_value;
    always_comb begin
        read_value = 32'h0000_0000;
        if (hit_expected) begin
            read_value = {24'h00_0000, expected_octet[slot]};
        end else if (hit_ignore) begin
            read_value = {24'h00_0000, ignore_octet[slot]};
        end else if (hit_counts) begin
            read_value = {cells_blocked, cells_passed};
        end else if (hit_errors) begin
            read_value = {stray_octets, cells_truncated};
        end
    end

    // answer registered in the setup cycle, so access lasts exactly one cycle
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end else if (setup_phase) begin
            pready_out  <= 1'b1;
            prdata_out  <= pwrite_in ? 32'h0000_0000 : read_value;
            pslverr_out <= !hit_any;
        end else begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0000_0000;
            pslverr_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // header and mask registers
    // ------------------------------------------------------------------
    // expected pattern, all zero after reset
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            expected_octet[0] <= EXPECTED_RST;
            expected_octet[1] <= EXPECTED_RST;
            expected_octet[2] <= EXPECTED_RST;
            expected_octet[3] <= EXPECTED_RST;
        end else if (wr_expected) begin
            expected_octet[slot] <= pwdata_in[7:0];
        end
    end

    // ignore masks, all ones after reset so every cell passes until programmed
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ignore_octet[0] <= IGNORE_RST;
            ignore_octet[1] <= IGNORE_RST;
            ignore_octet[2] <= IGNORE_RST;
            ignore_octet[3] <= IGNORE_RST;
        end else if (wr_ignore) begin
            ignore_octet[slot] <= pwdata_in[7:0];
        end
    end

    // full 32-bit pattern and mask, octet 1 in the top byte
    wire logic [31:0] expected_word = {expected_octet[0], expected_octet[1],
                                       expected_octet[2], expected_octet[3]};
    wire logic [31:0] ignore_word   = {ignore_octet[0], ignore_octet[1],
                                       ignore_octet[2], ignore_octet[3]};

    // ------------------------------------------------------------------
    // cell framing
    // ------------------------------------------------------------------
    logic        in_cell;
    logic [5:0]  octet_idx;
    logic [23:0] hdr_hold;
    logic        pass_cell;

    wire logic start_beat  = rx_valid_in && rx_beat_in.start;
    wire logic cont_beat   = rx_valid_in && !rx_beat_in.start && in_cell;
    wire logic stray_beat  = rx_valid_in && !rx_beat_in.start && !in_cell;
    // a new start while a cell is still open cuts the open one short
    wire logic truncation  = start_beat && in_cell;
    wire logic hdr_beat    = cont_beat && (octet_idx < LAST_HDR_IDX);
    wire logic hdr_done    = cont_beat && (octet_idx == LAST_HDR_IDX);
    wire logic body_beat   = cont_beat && (octet_idx > LAST_HDR_IDX);
    wire logic last_beat   = cont_beat && (octet_idx == LAST_IDX);

    // header word completes with the fourth octet
    wire logic [31:0] hdr_word = {hdr_hold, rx_beat_in.octet};

    // screening: masked bits never mismatch, all mask bits act together
    wire logic [31:0] hdr_diff     = hdr_word ^ expected_word;
    wire logic [31:0] hdr_mismatch = hdr_diff & ~ignore_word;
    wire logic        hdr_accept   = (hdr_mismatch == 32'h0000_0000);

    // octet position and cell state
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            in_cell   <= 1'b0;
            octet_idx <= 6'd0;
        end else if (start_beat) begin
            in_cell   <= 1'b1;
            octet_idx <= 6'd1;
        end else if (last_beat) begin
            in_cell   <= 1'b0;
            octet_idx <= 6'd0;
        end else if (cont_beat) begin
            octet_idx <= octet_idx + 6'd1;
        end
    end

    // header octets shift in until the fourth one arrives
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            hdr_hold <= 24'h00_0000;
        end else if (start_beat) begin
            hdr_hold <= {16'h0000, rx_beat_in.octet};
        end else if (hdr_beat) begin
            hdr_hold <= {hdr_hold[15:0], rx_beat_in.octet};
        end
    end

    // verdict kept for the rest of the cell
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            pass_cell <= 1'b0;
        end else if (start_beat) begin
            pass_cell <= 1'b0;
        end else if (hdr_done) begin
            pass_cell <= hdr_accept;
        end
    end

    // ------------------------------------------------------------------
    // forwarding toward the host cell port
    // ------------------------------------------------------------------
    // header goes out as one beat once decided; hec and payload follow octet by
    // octet. no buffer: the host port must take one beat per cycle.
    wire logic send_header = hdr_done && hdr_accept;
    wire logic send_body   = body_beat && pass_cell;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            fwd_valid_out <= 1'b0;
            fwd_beat_out  <= '0;
        end else if (send_header) begin
            fwd_valid_out       <= 1'b1;
            fwd_beat_out.start  <= 1'b1;
            fwd_beat_out.header <= hdr_word;
            fwd_beat_out.octet  <= 8'h00;
        end else if (send_body) begin
            fwd_valid_out       <= 1'b1;
            fwd_beat_out.start  <= 1'b0;
            fwd_beat_out.octet  <= rx_beat_in.octet;
        end else begin
            fwd_valid_out       <= 1'b0;
            fwd_beat_out.start  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // statistics
    // ------------------------------------------------------------------
    // counters saturate so software never sees a wrap as a small count;
    // an event in the same cycle as a clear is kept as a count of one
    wire logic passed_event  = hdr_done && hdr_accept;
    wire logic blocked_event = hdr_done && !hdr_accept;

    // cells that passed the screen; cleared with the blocked count
    sat_counter #(
        .WIDTH ($bits(cells_passed))
    ) u_passed_count (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clear_in  (clr_counts),
        .event_in  (passed_event),
        .count_out (cells_passed)
    );

    // cells whose header failed the screen
    sat_counter #(
        .WIDTH ($bits(cells_blocked))
    ) u_blocked_count (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clear_in  (clr_counts),
        .event_in  (blocked_event),
        .count_out (cells_blocked)
    );

    // cells cut short by a new start octet
    sat_counter #(
        .WIDTH ($bits(cells_truncated))
    ) u_truncated_count (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clear_in  (clr_errors),
        .event_in  (truncation),
        .count_out (cells_truncated)
    );

    // octets seen with no cell open; a hint of lost framing upstream
    sat_counter #(
        .WIDTH ($bits(stray_octets))
    ) u_stray_count (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .clear_in  (clr_errors),
        .event_in  (stray_beat),
        .count_out (stray_octets)
    );

endmodule // rx_cell_header_screen

// saturating event counter; a clear and an event in the same cycle give a count of one
module sat_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk_in,
    input  wire logic             reset_in,
    input  wire logic             clear_in,
    input  wire logic             event_in,
    output logic      [WIDTH-1:0] count_out
);

    localparam logic [WIDTH-1:0] STEP = {{(WIDTH-1){1'b0}}, 1'b1};

    // clear first, then count on top, so a same-cycle event is never lost
    wire logic [WIDTH-1:0] base       = clear_in ? '0 : count_out;
    wire logic             at_top     = &base; // stop at all ones, never wrap
    wire logic [WIDTH-1:0] next_count = (event_in && !at_top) ? base + STEP : base;

    // count register
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            count_out <= '0;
        end else begin
            count_out <= next_count;
        end
    end

endmodule // sat_counter

// >>> rtl/rx_screen_pkg.sv
// constants, register map and carrier types of the receive cell header screen
// Operation
// - expected second header octet register at index 0x19, resets to zero
// - expected third header octet register at index 0x1a, resets to zero
// - expected fourth header octet register at index 0x1b, resets to zero
// - every incoming cell header is compared against the programmed expected pattern
// - a mask bit of one makes that header bit position match always
// - mask is 32 bits, one per header bit, four byte registers
// - first octet mask register at index 0x1c, resets to all ones
// - second octet mask register at index 0x1d, resets to all ones
// - third octet mask register at index 0x1e, resets to all ones
// - any mix of mask bits applies together, selecting groups of paths
// - cells whose header passes are forwarded toward the host cell port
// - expected first header octet register at index 0x18
// - fourth octet mask register at index 0x1f, resets to all ones
package rx_screen_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EXPECTED_OCTET1 = 8'h18;
    localparam logic [7:0] IDX_EXPECTED_OCTET2 = 8'h19;
    localparam logic [7:0] IDX_EXPECTED_OCTET3 = 8'h1a;
    localparam logic [7:0] IDX_EXPECTED_OCTET4 = 8'h1b;
    localparam logic [7:0] IDX_IGNORE_OCTET1   = 8'h1c;
    localparam logic [7:0] IDX_IGNORE_OCTET2   = 8'h1d;
    localparam logic [7:0] IDX_IGNORE_OCTET3   = 8'h1e;
    localparam logic [7:0] IDX_IGNORE_OCTET4   = 8'h1f;
    localparam logic [7:0] IDX_CELL_COUNTS     = 8'h28;
    localparam logic [7:0] IDX_FRAME_ERRORS    = 8'h29;

    localparam int          ADDR_W      = 10;
    localparam int          IDX_LSB     = 2;
    localparam logic [7:0]  EXPECTED_RST = 8'h00;
    localparam logic [7:0]  IGNORE_RST   = 8'hff;

    // cell framing
    localparam logic [5:0]  CELL_OCTETS  = 6'd53;
    localparam logic [5:0]  LAST_HDR_IDX = 6'd3;
    localparam logic [5:0]  LAST_IDX     = 6'd52;
    localparam logic [15:0] COUNT_MAX    = 16'hffff;

    // beat carried toward the host cell port
    typedef struct packed {
        logic        start;
        logic [31:0] header;
        logic [7:0]  octet;
    } fwd_beat_s;

    // incoming octet from the receive cell path
    typedef struct packed {
        logic       start;
        logic [7:0] octet;
    } rx_beat_s;

endpackage

// >>> test/cell_source.sv
// model of the receive link handing cells octet by octet
`timescale 1ns/1ns
module cell_source
    import rx_screen_pkg::*;
(
    input  wire logic clk_in,
    output logic      valid_out,
    output rx_beat_s  beat_out
);
    initial begin
        valid_out = 1'b0;
        beat_out = '0;
    end

    // one 53-octet cell with a gap after octet 9; idle octet flips so stale data never matches
    task automatic send_cell(input logic [31:0] hdr, input logic [7:0] base);
        for (int i = 0; i < 53; i++) begin
            @(posedge clk_in);
            if (i == 9) begin
                valid_out <= 1'b0;
                beat_out.octet <= ~beat_out.octet;
                @(posedge clk_in);
            end
            valid_out <= 1'b1;
            beat_out.start <= (i == 0);
            beat_out.octet <= (i < 4) ? hdr[31-8*i -: 8] : base + 8'(i);
        end
        @(posedge clk_in);
        valid_out <= 1'b0;
        beat_out.start <= 1'b0;
        beat_out.octet <= ~beat_out.octet;
    endtask
endmodule // cell_source

// >>> test/rx_screen_props.sv
// port checker for the receive cell header screen
`timescale 1ns/1ns
module rx_screen_props
    import rx_screen_pkg::*;
(
    input wire logic        mclk_in,
    input wire logic        reset_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        rx_valid_in,
    input wire rx_beat_s    rx_beat_in,
    input wire logic        fwd_valid_out,
    input wire fwd_beat_s   fwd_beat_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    // apb answers in the cycle after setup, for one cycle only
    property p_ready_next; psel_in && !penable_in |=> pready_out; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    property p_ready_once; pready_out |=> !pready_out; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held");
    property p_data_idle; !pready_out |-> prdata_out == 32'h0; endproperty
    a_data_idle: assert property (p_data_idle) else $error("prdata not idle");
    // counter registers use the full word, so only the byte registers are held to it
    property p_upper_zero;
        pready_out && !pwrite_in && (paddr_in[IDX_LSB +: 8] <= IDX_IGNORE_OCTET4) |->
            prdata_out[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
    // forwarded beats trace back to the octet taken one edge earlier
    property p_fwd_cause; fwd_valid_out |-> $past(rx_valid_in); endproperty
    a_fwd_cause: assert property (p_fwd_cause) else $error("beat without octet");
    property p_hdr_tail;
        fwd_valid_out && fwd_beat_out.start |->
            fwd_beat_out.header[7:0] == $past(rx_beat_in.octet) && fwd_beat_out.octet == 8'h0;
    endproperty
    a_hdr_tail: assert property (p_hdr_tail) else $error("header beat wrong");
    property p_pay_copy;
        fwd_valid_out && !fwd_beat_out.start |-> fwd_beat_out.octet == $past(rx_beat_in.octet);
    endproperty
    a_pay_copy: assert property (p_pay_copy) else $error("payload octet wrong");
    property p_no_spare; fwd_valid_out && !rx_valid_in |=> !fwd_valid_out; endproperty
    a_no_spare: assert property (p_no_spare) else $error("beat in gap");

    c_start: cover property (fwd_valid_out && fwd_beat_out.start);
    c_err: cover property (pslverr_out);
    c_read: cover property (pready_out && !pwrite_in);
endmodule // rx_screen_props

// >>> test/testbench.sv
// self-checking bench for the receive cell header screen
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module testbench
    import rx_screen_pkg::*;
;
    logic mclk_in, reset_in, psel_in, penable_in, pwrite_in;
    logic [ADDR_W-1:0] paddr_in;
    logic [31:0]       pwdata_in, prdata_out, last_hdr, rd;
    logic [3:0]        pstrb_in;
    logic              pready_out, pslverr_out, rx_valid_in, fwd_valid_out, err;
    rx_beat_s          rx_beat_in;
    fwd_beat_s         fwd_beat_out;
    int                bad_count, n_compared, starts, beats, cycles;

    rx_cell_header_screen u_rx_cell_header_screen (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .psel_in       (psel_in),
        .penable_in    (penable_in),
        .pwrite_in     (pwrite_in),
        .paddr_in      (paddr_in),
        .pwdata_in     (pwdata_in),
        .pstrb_in      (pstrb_in),
        .prdata_out    (prdata_out),
        .pready_out    (pready_out),
        .pslverr_out   (pslverr_out),
        .rx_valid_in   (rx_valid_in),
        .rx_beat_in    (rx_beat_in),
        .fwd_valid_out (fwd_valid_out),
        .fwd_beat_out  (fwd_beat_out)
    );
    cell_source u_cell_source (.clk_in(mclk_in), .valid_out(rx_valid_in), .beat_out(rx_beat_in));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // hang guard, far above the roughly six hundred cycles needed
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // forwarded beats observed mid-cycle, where they are settled
    always @(negedge mclk_in) if (fwd_valid_out === 1'b1) begin
        if (fwd_beat_out.start) begin
            starts++;
            last_hdr = fwd_beat_out.header;
            beats = 0;
        end else beats++;
    end

    // one apb transfer; request held until pready seen, answer taken at that edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge mclk_in);
        psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w;
        paddr_in <= {idx, 2'b00}; pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        // pready seen at the rising edge itself; the request is still standing there
        do @(posedge mclk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic regs_reset;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'h18 + 8'(i), 32'h0);
            `CHK("reset value", (i < 4) ? 32'h0 : 32'hff, rd)
        end
    endtask

    // upper write bits are dropped; an unmapped index is refused
    task automatic regs_rw;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h5a ^ 8'(i * 17);
            apb(1'b1, 8'h18 + 8'(i), {24'hffffff, v});
            apb(1'b0, 8'h18 + 8'(i), 32'h0);
            `CHK("readback", {24'h0, v}, rd)
        end
        apb(1'b0, 8'hff, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        // a write without the low byte strobe leaves the register alone
        pstrb_in <= 4'h0;
        apb(1'b1, 8'h18, 32'h77);
        pstrb_in <= 4'hf;
        apb(1'b0, 8'h18, 32'h0);
        `CHK("strobe off write", 32'h5a, rd)
    endtask

    task automatic set_screen(input logic [31:0] hdr, input logic [31:0] msk);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h18 + 8'(i), {24'h0, hdr[31-8*i -: 8]});
            apb(1'b1, 8'h1c + 8'(i), {24'h0, msk[31-8*i -: 8]});
        end
    endtask

    task automatic screen(input logic [31:0] hdr, input int pass);
        int s0;
        s0 = starts;
        u_cell_source.send_cell(hdr, 8'h40);
        repeat (3) @(posedge mclk_in);
        `CHK("cells forwarded", pass, starts - s0)
        if (pass == 1) begin
            `CHK("header", hdr, last_hdr)
            `CHK("payload beats", 49, beats)
        end
    endtask

    initial begin
        reset_in = 1'b1; psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0;
        paddr_in = '0; pwdata_in = '0; pstrb_in = 4'hf;
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        regs_reset();
        screen(32'hdeadbeef, 1);
        regs_rw();
        set_screen(32'h12345678, 32'h0);
        screen(32'h12345678, 1);
        for (int i = 0; i < 4; i++) screen(32'h12345678 ^ (32'h8 << 8*i), 0);
        set_screen(32'h12345678, 32'h000f0001);
        screen(32'h123a5679, 1);
        screen(32'h12b45678, 0);
        // three cells passed and five were blocked so far
        apb(1'b0, 8'h28, 32'h0);
        `CHK("pass block counts", 32'h0005_0003, rd)
        end_sim();
    end
endmodule // testbench

bind rx_cell_header_screen rx_screen_props u_props (.*);
